// ### pkg/psf_defs.vh
// constants and field layout for the pixel serial framer
`ifndef PSF_DEFS_VH
`define PSF_DEFS_VH

// operating mode codes
`define PSF_MODE_NATIVE     2'b00
`define PSF_MODE_NATIVE_FLT 2'b01
`define PSF_MODE_GEN2       2'b10
`define PSF_MODE_GEN1       2'b11

// serial word layout
`define PSF_WORD_BITS    28
`define PSF_BIT_MARK_HI  27
`define PSF_BIT_INTEG    26
`define PSF_BIT_BALANCE  25
`define PSF_BIT_MARK_LO  0
`define PSF_LANE_POS     7
`define PSF_LANE_LAST    3'h6

// scrambler, must match the far descrambler
`define PSF_SCR_POLY     24'he10000
`define PSF_SCR_SEED     24'h5a5a5a

// timing
`define PSF_CLK_MHZ      40
`define PSF_LOCK_US      1500
`define PSF_LOCK_CYCLES  (`PSF_LOCK_US * `PSF_CLK_MHZ)
`define PSF_STOP_NS      333
`define PSF_STOP_CYCLES  ((`PSF_STOP_NS * `PSF_CLK_MHZ) / 1000)
`define PSF_DELAY_WORDS  139
`define PSF_FLT_WINDOW   130
`define PSF_FLT_MAX_TR   2
`define PSF_FLT_MIN_PULSE 3

`endif

// ### src/psf_delay_ram.v
// word delay memory with registered read data
`timescale 1ns/1ps
module psf_delay_ram #(
  parameter WIDTH = 28,
  parameter AW    = 8
) (
  input  wire             i_clock,
  input  wire             i_wr_en,
  input  wire [AW-1:0]    i_wr_addr,
  input  wire [WIDTH-1:0] i_wr_data,
  input  wire [AW-1:0]    i_rd_addr,
  output reg  [WIDTH-1:0] o_rd_data
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // no reset: contents are never read before being written
  always @(posedge i_clock) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule // psf_delay_ram

// ### src/psf_framer.v
// pixel serial framer: lane capture, filter, scramble, balance, delay
`timescale 1ns/1ps
`include "psf_defs.vh"
module psf_framer #(
  parameter LOCK_CYCLES = `PSF_LOCK_CYCLES,
  parameter DELAY_WORDS = `PSF_DELAY_WORDS,
  parameter AW          = 8
) (
  input  wire        i_clock,
  input  wire        i_reset_n,
  input  wire        i_lvds_pixel_clock_in,
  input  wire [3:0]  i_lvds_data_lanes,
  input  wire [1:0]  i_strap_mode,
  input  wire        i_strap_color_18bit,
  input  wire        i_bus_select,
  input  wire [1:0]  i_bus_mode,
  input  wire        i_bus_color_18bit,
  output reg  [27:0] o_serial_word,
  output reg         o_word_valid,
  output reg         o_lines_high,
  output reg         o_locked,
  output reg         o_sleep
);
  localparam ST_SLEEP = 3'b001;
  localparam ST_LOCK  = 3'b010;
  localparam ST_RUN   = 3'b100;

  // pin synchronisers: clock, lanes, then straps and bus settings
  reg [11:0] sync1_q;
  reg [11:0] sync2_q;
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= 12'h000;
      sync2_q <= 12'h000;
    end else begin
      sync1_q <= {i_bus_color_18bit, i_bus_mode, i_bus_select, i_strap_color_18bit,
                  i_strap_mode, i_lvds_data_lanes, i_lvds_pixel_clock_in};
      sync2_q <= sync1_q;
    end
  end
  wire       pclk_s  = sync2_q[0];
  wire [3:0] lanes_s = sync2_q[4:1];

  // settings: power-down returns them to defaults, sleep keeps them
  reg [1:0] mode_q;
  reg       c18_q;
  reg       pclk_d1_q;
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q    <= `PSF_MODE_NATIVE;
      c18_q     <= 1'b0;
      pclk_d1_q <= 1'b0;
    end else begin
      mode_q    <= sync2_q[8] ? sync2_q[10:9] : sync2_q[6:5];
      c18_q     <= sync2_q[8] ? sync2_q[11] : sync2_q[7];
      pclk_d1_q <= pclk_s;
    end
  end
  wire pclk_rise = pclk_s & ~pclk_d1_q;
  wire native    = ~mode_q[1];
  wire flt_on    = (mode_q == `PSF_MODE_NATIVE_FLT);
  wire gen1      = (mode_q == `PSF_MODE_GEN1);

  // seven strobes per pixel clock, one per system cycle after the edge
  reg [2:0] pos_q;
  reg       samp_q;
  reg [6:0] lane_q [0:3];
  reg       pix_rdy_q;
  integer   k;
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pos_q     <= 3'h0;
      samp_q    <= 1'b0;
      pix_rdy_q <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        lane_q[k] <= 7'h00;
      end
    end else begin
      pix_rdy_q <= samp_q && (pos_q == `PSF_LANE_LAST);
      if (pclk_rise) begin
        pos_q  <= 3'h0;
        samp_q <= 1'b1;
      end else if (samp_q) begin
        for (k = 0; k < 4; k = k + 1) begin
          lane_q[k][pos_q] <= lanes_s[k];
        end
        pos_q  <= pos_q + 3'h1;
        samp_q <= (pos_q != `PSF_LANE_LAST);
      end
    end
  end

  // lane map: lanes 0..2 and lane 3 low bits colour, lane 3 upper controls
  wire [23:0] raw_col = {lane_q[3][2:0], lane_q[2], lane_q[1], lane_q[0]};
  wire [2:0]  raw_ctl = {lane_q[3][5], lane_q[3][4], lane_q[3][3]}; // vs, hs, de

  // link lock and stop-clock sleep
  reg [2:0]  st_q;
  reg [31:0] lock_cnt_q;
  reg [7:0]  idle_cnt_q;
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q       <= ST_SLEEP;
      lock_cnt_q <= 32'h0;
      idle_cnt_q <= 8'h00;
    end else begin
      idle_cnt_q <= pclk_rise ? 8'h00 : (idle_cnt_q == 8'hff ? idle_cnt_q : idle_cnt_q + 8'h01);
      case (st_q)
        ST_SLEEP: begin
          lock_cnt_q <= 32'h0;
          if (pclk_rise) begin
            st_q <= ST_LOCK;
          end
        end
        ST_LOCK: begin
          if (idle_cnt_q > `PSF_STOP_CYCLES) begin
            st_q <= ST_SLEEP;
          end else if (lock_cnt_q >= LOCK_CYCLES - 1) begin
            st_q <= ST_RUN;
          end else begin
            lock_cnt_q <= lock_cnt_q + 32'h1;
          end
        end
        ST_RUN: begin
          if (idle_cnt_q > `PSF_STOP_CYCLES) begin
            st_q <= ST_SLEEP;
          end
        end
        default: st_q <= ST_SLEEP;
      endcase
    end
  end
  wire running = (st_q == ST_RUN);

  // control filter on data enable and horizontal sync, per pixel
  reg [7:0] win_q;
  reg [1:0] ctl_q;
  reg [1:0] stab_q [0:1];
  reg [1:0] trn_q  [0:1];
  wire [1:0] ctl_n;
  wire      win_end = (win_q == `PSF_FLT_WINDOW - 1);
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_flt
      wire diff = raw_ctl[g] ^ ctl_q[g];
      wire pass = flt_on ? (stab_q[g] == `PSF_FLT_MIN_PULSE - 1) && (trn_q[g] < `PSF_FLT_MAX_TR) : 1'b1;
      // the word of this same pixel carries the filtered level, so controls stay aligned with colour
      assign ctl_n[g] = (diff && pass) ? raw_ctl[g] : ctl_q[g];
      always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          ctl_q[g]  <= 1'b0;
          stab_q[g] <= 2'h0;
          trn_q[g]  <= 2'h0;
        end else if (pix_rdy_q) begin
          stab_q[g] <= (diff && !pass) ? stab_q[g] + 2'h1 : 2'h0;
          if (diff && pass) begin
            ctl_q[g] <= raw_ctl[g];
          end
          // a transition in the wrap cycle is counted into the new window
          if (win_end) begin
            trn_q[g] <= (diff && pass) ? 2'h1 : 2'h0;
          end else if (diff && pass) begin
            trn_q[g] <= trn_q[g] + 2'h1;
          end
        end
      end
    end
  endgenerate
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      win_q <= 8'h00;
    end else if (pix_rdy_q) begin
      win_q <= win_end ? 8'h00 : win_q + 8'h01;
    end
  end
  // vertical sync is not filtered
  wire [2:0] ctl = {raw_ctl[2], ctl_n};

  // encoder: scramble, integrity code, balance
  reg  [23:0] lfsr_q;
  reg  [1:0]  slot_q;
  reg  [7:0]  rd_q;
  reg  [23:0] col;
  reg  [24:0] pay;
  reg         integ;
  reg  [7:0]  disp;
  reg         inv;
  reg  [27:0] word;
  integer     b;
  always @* begin
    col = raw_col;
    if (c18_q) begin
      col = {ctl, raw_col[20:0] & 21'h1fffff};
    end else if (!native) begin
      col = {ctl, raw_col[20:0]};
    end
    if (!gen1) begin
      col = col ^ lfsr_q;
    end
    integ = ^col;
    if (native && !c18_q && slot_q != 2'h0) begin
      integ = ctl[slot_q - 2'h1];
    end
    pay  = {integ, col};
    disp = 8'h00;
    for (b = 0; b < 25; b = b + 1) begin
      disp = pay[b] ? disp + 8'h01 : disp - 8'h01;
    end
    // invert when both disparities share a sign
    inv  = (disp != 8'h00) && (disp[7] == rd_q[7]) && (rd_q != 8'h00);
    word = {1'b1, 2'b00, col, 1'b0};
    word[`PSF_BIT_INTEG]   = integ ^ inv;
    word[`PSF_BIT_BALANCE] = inv;
    word[24:1] = col ^ {24{inv}};
  end
  wire [23:0] lfsr_n = lfsr_q[0] ? ((lfsr_q >> 1) ^ `PSF_SCR_POLY) : (lfsr_q >> 1);
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lfsr_q <= `PSF_SCR_SEED;
      slot_q <= 2'h0;
      rd_q   <= 8'h00;
    end else if (pix_rdy_q) begin
      lfsr_q <= lfsr_n;
      slot_q <= slot_q + 2'h1;
      // the flag bit is on the line too: +1 when set, -1 when clear
      rd_q   <= inv ? rd_q - disp + 8'h01 : rd_q + disp - 8'h01;
    end
  end

  // fixed delay line sets the input-to-output latency
  reg  [AW-1:0] wp_q;
  reg  [8:0]    fill_q;
  reg           rd_vld_q;
  wire [27:0]   rd_word;
  wire [31:0]   delay_32 = DELAY_WORDS;
  wire [AW-1:0] delay_w  = delay_32[AW-1:0];
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp_q     <= {AW{1'b0}};
      fill_q   <= 9'h000;
      rd_vld_q <= 1'b0;
    end else begin
      rd_vld_q <= pix_rdy_q && (fill_q >= DELAY_WORDS) && running;
      if (pix_rdy_q) begin
        wp_q <= wp_q + 1'b1;
        if (fill_q < DELAY_WORDS) begin
          fill_q <= fill_q + 9'h001;
        end
      end
      if (!running) begin
        fill_q <= 9'h000;
      end
    end
  end

  psf_delay_ram #(
    .WIDTH (28),
    .AW    (AW)
  ) u_delay (
    .i_clock   (i_clock),
    .i_wr_en   (pix_rdy_q),
    .i_wr_addr (wp_q),
    .i_wr_data (word),
    .i_rd_addr (wp_q - delay_w),
    .o_rd_data (rd_word)
  );

  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_serial_word <= 28'h0000000;
      o_word_valid  <= 1'b0;
      o_lines_high  <= 1'b1;
      o_locked      <= 1'b0;
      o_sleep       <= 1'b1;
    end else begin
      o_word_valid <= rd_vld_q;
      if (rd_vld_q) begin
        o_serial_word <= rd_word;
      end
      o_lines_high <= !running;
      o_locked     <= running;
      o_sleep      <= (st_q == ST_SLEEP);
    end
  end
endmodule // psf_framer

// ### verification/psf_monitor.sv
// assertion checker on the framer ports
`timescale 1ns/1ps
module psf_monitor #(
  parameter LOCK_CYCLES = 20
) (
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  input wire logic [27:0] o_serial_word,
  input wire logic        o_word_valid,
  input wire logic        o_lines_high,
  input wire logic        o_locked,
  input wire logic        o_sleep
);
  int run_q;
  // cycles since leaving sleep; saturates so a long run cannot wrap
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) run_q <= 0;
    else if (o_sleep) run_q <= 0;
    else if (run_q < LOCK_CYCLES) run_q <= run_q + 1;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  a_mark_high: assert property (o_word_valid |-> o_serial_word[27])
    else $error("marker high missing");
  a_mark_low: assert property (o_word_valid |-> !o_serial_word[0])
    else $error("marker low missing");
  a_word_locked: assert property (o_word_valid |-> o_locked && !o_lines_high)
    else $error("word while not locked");
  a_lines_idle: assert property (!o_locked |-> o_lines_high && !o_word_valid)
    else $error("lines not high");
  a_word_rate: assert property (o_word_valid |=> !o_word_valid [*6])
    else $error("words too close");
  a_word_held: assert property (!o_word_valid && o_locked |-> $stable(o_serial_word))
    else $error("word changed between valids");
  a_sleep_state: assert property (o_sleep |-> !o_locked && o_lines_high)
    else $error("sleep while running");
  a_lock_time: assert property ($rose(o_locked) |-> run_q >= LOCK_CYCLES)
    else $error("lock too early");
  a_reset_exit: assert property ($rose(i_reset_n) |-> o_lines_high && !o_locked)
    else $error("bad state after reset");
endmodule // psf_monitor
bind psf_framer psf_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) u_mon (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .o_serial_word(o_serial_word),
  .o_word_valid(o_word_valid), .o_lines_high(o_lines_high), .o_locked(o_locked), .o_sleep(o_sleep));

// ### verification/psf_host_model.sv
// host pixel source: pixel clock and seven-position lane data
`timescale 1ns/1ps
module psf_host_model (
  input  wire logic        i_run,
  input  wire logic [27:0] i_pixel,
  output logic             o_pixel_clock,
  output logic [3:0]       o_lanes
);
  logic [27:0] px;
  // edges land 2 ns after a system edge; clock stands low while stopped
  initial begin
    o_pixel_clock = 0;
    o_lanes = 0;
    #14.5;
    forever begin
      if (!i_run) #200;
      else begin
        px = i_pixel;
        o_pixel_clock = 1;
        for (int p = 0; p < 7; p++) begin
          #25;
          o_lanes = {px[21+p], px[14+p], px[7+p], px[p]};
          if (p == 3) o_pixel_clock = 0;
        end
        #25;
      end
    end
  end
endmodule // psf_host_model

// ### verification/pixel_serial_framer_tb.sv
// self-checking bench for the framer
`timescale 1ns/1ps
`include "psf_defs.vh"
module pixel_serial_framer_tb;
  localparam int DW = 4;
  logic        i_clock = 0, i_reset_n = 0, run = 0, bsel = 0, s18 = 0, b18 = 0;
  logic [1:0]  smode = 0, bmode = 0;
  logic [27:0] pixel = 0, word;
  logic [27:0] hist[256];
  logic [23:0] fld;
  logic [7:0]  lat;
  logic [3:0]  lanes;
  logic        pclk, valid, lines_high, locked, sleep;
  bit          gen1 = 0, live = 0, c18 = 0, have_prev = 0;
  logic [1:0]  md = 0;
  logic [7:0]  sidx;
  logic [27:0] src;
  logic [23:0] lprev;
  int          err_count = 0, samples_checked = 0, n = 0, cyc = 0, hits = 0, rd = 0;

  psf_host_model u_host (.i_run(run), .i_pixel(pixel), .o_pixel_clock(pclk), .o_lanes(lanes));
  psf_framer #(.LOCK_CYCLES(20), .DELAY_WORDS(DW)) DUT (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_lvds_pixel_clock_in(pclk),
    .i_lvds_data_lanes(lanes), .i_strap_mode(smode), .i_strap_color_18bit(s18),
    .i_bus_select(bsel), .i_bus_mode(bmode), .i_bus_color_18bit(b18), .o_serial_word(word),
    .o_word_valid(valid), .o_lines_high(lines_high), .o_locked(locked), .o_sleep(sleep));

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // unscrambled layout of the compatibility framing
  function automatic logic [23:0] plain_field(logic [27:0] p);
    return {p[26:24], p[20:0]};
  endfunction
  // colour field before scrambling for the settings of the running phase
  function automatic logic [23:0] exp_field(logic [27:0] p);
    return (md[1] || c18) ? plain_field(p) : p[23:0];
  endfunction
  function automatic logic [23:0] lf_step(logic [23:0] s);
    return s[0] ? ((s >> 1) ^ `PSF_SCR_POLY) : (s >> 1);
  endfunction

  initial forever #12.5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 12000) begin
      err_count++;
      complete_run();
    end
  end
  // low byte of each pixel is its index, so a word finds its source
  always @(posedge pclk) begin
    hist[n[7:0]] = pixel;
    n++;
    #1 pixel = {$urandom(), n[7:0]};
  end
  always @(posedge i_clock) begin
    if (valid) begin
      fld = word[24:1] ^ {24{word[25]}};
      rd += 2 * $countones(word) - 28;
      check("disparity", rd > -120 && rd < 120, 1);
      lat = n[7:0] - fld[7:0];
      // a word leaves DW + 1 pixel edges after its own, so its index is n - (DW + 2)
      sidx = n[7:0] - 8'(DW + 2);
      src = hist[sidx];
      if (gen1) begin
        check("field", fld, plain_field(hist[fld[7:0]]));
        check("integrity", word[26] ^ word[25], ^fld);
        check("latency", lat >= DW && lat <= DW + 6, 1);
      end else if (live) begin
        if (fld === plain_field(hist[fld[7:0]])) hits++;
        if (md[1] || c18) check("integrity", word[26] ^ word[25], ^fld);
        // filtered controls inside the field are not modelled
        if (md != 2'h1 || !c18) begin
          if (have_prev) check("scramble", fld ^ exp_field(src), lf_step(lprev));
          lprev = fld ^ exp_field(src);
          have_prev = 1;
        end
      end
    end
  end

  // sel: settings from bus pins while straps ask for the opposite mode
  task automatic phase(bit sel, logic [1:0] m);
    @(posedge i_clock);
    #2;
    gen1 = 0;
    live = 0;
    have_prev = 0;
    bsel = sel;
    smode = sel ? ~m : m;
    bmode = m;
    s18 = $urandom();
    b18 = $urandom();
    md = m;
    c18 = sel ? b18 : s18;
    repeat (20) @(posedge pclk);
    gen1 = (m == 2'h3);
    live = 1;
    hits = 0;
    repeat (30) @(posedge pclk);
    if (m != 2'h3) check("plain_hits", hits, 0);
    check("locked", locked, 1);
  endtask

  initial begin
    void'($urandom(82829));
    repeat (4) @(posedge i_clock);
    #2 i_reset_n = 1;
    run = 1;
    for (int i = 0; i < 8; i++) phase(i[2], i[1:0]);
    run = 0;
    repeat (30) @(posedge i_clock);
    check("sleep", {sleep, lines_high, locked}, 3'h6);
    run = 1;
    phase(1, 2'h3);
    @(posedge i_clock);
    #2 i_reset_n = 0;
    @(posedge i_clock);
    #2 check("reset", {valid, lines_high, locked, sleep, word}, {4'h5, 28'h0});
    rd = 0;
    i_reset_n = 1;
    phase(0, 2'h3);
    complete_run();
  end
endmodule // pixel_serial_framer_tb
